// ---- rtl/cws_pkg.sv ----
/*
 * constants for the cpu clock select and oscillator watchdog block:
 * register map, field positions, reset values, strap codes, timing counts.
 * assumes a 10 MHz system clock and a 32-bit apb register bus.
 */
package cws_pkg;

	// ****************************************
	// clock and timing
	// ****************************************
	localparam int MCLK_HZ = 10000000;
	localparam int SYNC_STAGES = 2;
	localparam logic [1:0] STRAP_SETTLE_CYC = 2'(SYNC_STAGES + 1);
	localparam logic [4:0] OWD_OVERFLOW_CNT = 5'h10;

	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [7:0] SYSCFG_ADDR = 8'h00;
	localparam logic [7:0] IRQ_STATUS_ADDR = 8'h04;
	localparam logic [7:0] IRQ_MASK_ADDR = 8'h08;
	localparam logic [7:0] CLK_STATE_ADDR = 8'h0C;

	// ****************************************
	// fields and reset values
	// ****************************************
	localparam int SYSCFG_OWD_DIS_BIT = 4;
	localparam logic SYSCFG_OWD_DIS_RST = 1'b0;
	localparam int IRQ_OWD_BIT = 0;
	localparam logic IRQ_MASK_RST = 1'b0;
	localparam int STATE_STRAP_LSB = 0;
	localparam int STATE_FAILOVER_BIT = 4;
	localparam int STATE_PLL_ON_BIT = 5;
	localparam int STATE_WDCNT_LSB = 8;

	// ****************************************
	// strap codes and multiplication factors
	// ****************************************
	localparam logic [2:0] STRAP_X4 = 3'h7;
	localparam logic [2:0] STRAP_X3 = 3'h6;
	localparam logic [2:0] STRAP_X8 = 3'h5;
	localparam logic [2:0] STRAP_X5 = 3'h4;
	localparam logic [2:0] STRAP_DIRECT = 3'h3;
	localparam logic [2:0] STRAP_X10 = 3'h2;
	localparam logic [2:0] STRAP_PRESCALE = 3'h1;
	localparam logic [2:0] STRAP_X16 = 3'h0;
	localparam logic [2:0] STRAP_RST = STRAP_X4;
	localparam logic [4:0] FACTOR_ONE = 5'h01;

	typedef enum logic [1:0] {
		CWS_SRC_PLL,
		CWS_SRC_DIRECT,
		CWS_SRC_PRESCALE
	} cws_src_t;

endpackage

// ---- rtl/cws_clock_select.sv ----
/*
 * cpu clock source selection with strap capture at reset, 2:1 prescaler,
 * direct drive, pll factor selection and oscillator watchdog with failover.
 * assumes crystal input, pll clock and strap pins are asynchronous pins,
 * sampled on mclk; software/watchdog reset arrives synchronous to mclk.
 */

// Functional notes
// - straps sampled at reset release choose the cpu clock mechanism
// - strap codes map to x4,x3,x8,x5,direct,x10,div2,x16
// - code 001 derives cpu clock from oscillator through divide-by-two
// - prescaler: each cpu clock phase lasts one input clock period
// - code 011 bypasses pll and drives cpu clock straight from crystal
// - direct drive: phases follow input duty, two halves make one period
// - non-pll modes: pll free-runs for watchdog unless disable bit set
// - watchdog enabled after reset, disabled by config register bit 4
// - enabled watchdog counts pll clocks, cleared by every crystal transition
// - overflow after 16 pll clocks without crystal transition means failure
// - on overflow cpu clock moves to pll clock and interrupt flag sets
// - failover holds until hardware reset or software/watchdog reset
// - watchdog disabled in direct drive or prescaler modes without failover: cpu clock from oscillator and pll powered off
// - watchdog supervision only in direct drive or prescaler modes
// - both cpu clock edges are usable, each half period a timing unit
// - pll modes: input times factor, resynchronised every factor-th transition
module cws_clock_select (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic swRstReq,
	input wire logic crystalInputPin,
	input wire logic pllClkIn,
	input wire logic [2:0] clockModeStrapPins,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic cpuClk,
	output logic cpuEdge,
	output logic pllEnable,
	output logic [4:0] pllFactor,
	output logic pllResync,
	output logic owdIrq
);
	import cws_pkg::*;

	// ****************************************
	// input synchronisers
	// ****************************************
	logic xtalLevel;
	logic pllLevel;
	logic [2:0] strapSync;
	logic xtalLast_q;
	logic pllLast_q;

	cws_sync #(
		.WIDTH(1),
		.RST_VAL(1'b0)
	) i_xtal_sync (
		.mclk(mclk),
		.rstn(rstn),
		.pinIn(crystalInputPin),
		.syncOut(xtalLevel)
	);

	cws_sync #(
		.WIDTH(1),
		.RST_VAL(1'b0)
	) i_pll_sync (
		.mclk(mclk),
		.rstn(rstn),
		.pinIn(pllClkIn),
		.syncOut(pllLevel)
	);

	cws_sync #(
		.WIDTH(3),
		.RST_VAL(STRAP_RST)
	) i_strap_sync (
		.mclk(mclk),
		.rstn(rstn),
		.pinIn(clockModeStrapPins),
		.syncOut(strapSync)
	);

	// last synced levels; both pins idle low, so no false edge after reset
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			xtalLast_q <= 1'b0;
		end else begin
			xtalLast_q <= xtalLevel;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pllLast_q <= 1'b0;
		end else begin
			pllLast_q <= pllLevel;
		end
	end

	logic xtalToggle;
	logic xtalRise;
	logic pllRise;
	assign xtalToggle = xtalLevel ^ xtalLast_q;
	assign xtalRise = xtalLevel & ~xtalLast_q;
	assign pllRise = pllLevel & ~pllLast_q;

	// ****************************************
	// strap capture
	// ****************************************
	logic [1:0] settle_q;
	logic strapDone_q;
	logic [2:0] strap_q;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			settle_q <= '0;
			strapDone_q <= 1'b0;
			strap_q <= STRAP_RST;
		end else if (swRstReq) begin
			settle_q <= '0;
			strapDone_q <= 1'b0;
		end else if (!strapDone_q) begin
			if (settle_q == STRAP_SETTLE_CYC) begin
				strap_q <= strapSync;
				strapDone_q <= 1'b1;
			end else begin
				settle_q <= settle_q + 2'h1;
			end
		end
	end

	// ****************************************
	// mode decode
	// ****************************************
	cws_src_t mode;
	logic [4:0] factor;

	always_comb begin
		mode = CWS_SRC_PLL;
		factor = FACTOR_ONE;
		case (strap_q)
			STRAP_X4: factor = 5'h04;
			STRAP_X3: factor = 5'h03;
			STRAP_X8: factor = 5'h08;
			STRAP_X5: factor = 5'h05;
			STRAP_DIRECT: mode = CWS_SRC_DIRECT;
			STRAP_X10: factor = 5'h0A;
			STRAP_PRESCALE: mode = CWS_SRC_PRESCALE;
			STRAP_X16: factor = 5'h10;
			default: factor = FACTOR_ONE;
		endcase
	end

	// ****************************************
	// apb slave
	// ****************************************
	logic osc_watchdog_disable_q;
	logic irqStatus_q;
	logic irqMask_q;
	logic failover_q;
	logic [4:0] wdCnt_q;
	logic wrAcc;
	logic wdOverflow;

	assign wrAcc = psel & penable & pready & pwrite;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pready <= 1'b0;
		end else begin
			pready <= psel & ~penable & ~pready;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pslverr <= 1'b0;
			prdata <= '0;
			if (psel & ~penable & ~pready) begin
				case (paddr)
					SYSCFG_ADDR: prdata[SYSCFG_OWD_DIS_BIT] <= osc_watchdog_disable_q;
					IRQ_STATUS_ADDR: prdata[IRQ_OWD_BIT] <= irqStatus_q;
					IRQ_MASK_ADDR: prdata[IRQ_OWD_BIT] <= irqMask_q;
					CLK_STATE_ADDR: begin
						prdata[STATE_STRAP_LSB +: 3] <= strap_q;
						prdata[STATE_FAILOVER_BIT] <= failover_q;
						prdata[STATE_PLL_ON_BIT] <= pllEnable;
						prdata[STATE_WDCNT_LSB +: 5] <= wdCnt_q;
					end
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			osc_watchdog_disable_q <= SYSCFG_OWD_DIS_RST;
		end else if (wrAcc && paddr == SYSCFG_ADDR) begin
			osc_watchdog_disable_q <= pwdata[SYSCFG_OWD_DIS_BIT];
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			irqMask_q <= IRQ_MASK_RST;
		end else if (wrAcc && paddr == IRQ_MASK_ADDR) begin
			irqMask_q <= pwdata[IRQ_OWD_BIT];
		end
	end

	// set wins over a write-one clear in the same cycle
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			irqStatus_q <= 1'b0;
		end else if (wdOverflow) begin
			irqStatus_q <= 1'b1;
		end else if (wrAcc && paddr == IRQ_STATUS_ADDR && pwdata[IRQ_OWD_BIT]) begin
			irqStatus_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			owdIrq <= 1'b0;
		end else begin
			owdIrq <= (irqStatus_q | wdOverflow) & irqMask_q;
		end
	end

	// ****************************************
	// oscillator watchdog
	// ****************************************
	// supervision stops once failed over; only a reset re-arms it
	logic owdActive;
	assign owdActive = strapDone_q & ~osc_watchdog_disable_q & ~failover_q & (mode != CWS_SRC_PLL);
	assign wdOverflow = owdActive & pllRise & ~xtalToggle & (wdCnt_q == OWD_OVERFLOW_CNT - 5'h01);

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			wdCnt_q <= '0;
		end else if (swRstReq || !owdActive || xtalToggle) begin
			wdCnt_q <= '0;
		end else if (pllRise) begin
			wdCnt_q <= wdCnt_q + 5'h01;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			failover_q <= 1'b0;
		end else if (swRstReq) begin
			failover_q <= 1'b0;
		end else if (wdOverflow) begin
			failover_q <= 1'b1;
		end
	end

	// ****************************************
	// pll control and resync
	// ****************************************
	logic [4:0] xtalEdgeCnt_q;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pllEnable <= 1'b0;
		end else begin
			// on in pll modes or after failover, else free-running for watchdog, off when disabled
			pllEnable <= (mode == CWS_SRC_PLL) | ~osc_watchdog_disable_q | failover_q;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pllFactor <= FACTOR_ONE;
		end else begin
			pllFactor <= factor;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			xtalEdgeCnt_q <= '0;
			pllResync <= 1'b0;
		end else begin
			pllResync <= 1'b0;
			if (mode != CWS_SRC_PLL || !strapDone_q) begin
				xtalEdgeCnt_q <= '0;
			end else if (xtalToggle) begin
				// a smaller factor picked mid-count must not wait for a wrap
				if (xtalEdgeCnt_q >= factor - 5'h01) begin
					xtalEdgeCnt_q <= '0;
					pllResync <= 1'b1;
				end else begin
					xtalEdgeCnt_q <= xtalEdgeCnt_q + 5'h01;
				end
			end
		end
	end

	// ****************************************
	// cpu clock output
	// ****************************************
	logic cpuNext;

	always_comb begin
		cpuNext = cpuClk;
		if (failover_q || mode == CWS_SRC_PLL) begin
			cpuNext = pllLevel;
		end else if (mode == CWS_SRC_DIRECT) begin
			cpuNext = xtalLevel;
		end else if (xtalRise) begin
			cpuNext = ~cpuClk;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cpuClk <= 1'b0;
		end else begin
			cpuClk <= cpuNext;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cpuEdge <= 1'b0;
		end else begin
			cpuEdge <= cpuNext ^ cpuClk;
		end
	end

endmodule

// ****************************************
// two-flop synchroniser
// ****************************************
module cws_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] syncOut
);
	import cws_pkg::*;
	logic [WIDTH-1:0] meta_q;

	// only the second stage may be read by logic
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			meta_q <= RST_VAL;
			syncOut <= RST_VAL;
		end else begin
			meta_q <= pinIn;
			syncOut <= meta_q;
		end
	end
endmodule

// ---- verification/cws_clock_select_checker.sv ----
/*
 * port checker for the cpu clock select block.
 * assumes the top module ports of cws_clock_select, bound below.
 */
module cws_clock_select_checker
	import cws_pkg::*;
(
	input wire logic mclk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic cpuClk,
	input wire logic cpuEdge,
	input wire logic pllEnable,
	input wire logic [4:0] pllFactor,
	input wire logic pllResync,
	input wire logic owdIrq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic apbWr;
	logic setupPh;
	assign apbWr = psel && penable && pwrite;
	assign setupPh = psel && !penable;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
	a_ready_after_setup: assert property (pready |-> $past(setupPh)) else $error("pready not after setup");
	a_edge_marks: assert property (cpuEdge == $changed(cpuClk)) else $error("cpuEdge mismatch");
	a_factor_legal: assert property (pllFactor inside {5'h01, 5'h03, 5'h04, 5'h05, 5'h08, 5'h0A, 5'h10})
		else $error("illegal factor");
	a_resync_pll_only: assert property (pllResync |-> pllFactor != FACTOR_ONE) else $error("resync in bypass");
	a_resync_pulse: assert property (pllResync |=> !pllResync) else $error("resync too long");
	a_pll_off_bypass: assert property (!pllEnable |-> pllFactor == FACTOR_ONE) else $error("pll off in pll mode");
	a_irq_needs_pll: assert property ($rose(owdIrq) |-> pllEnable) else $error("failover without pll");
	a_irq_sticky: assert property ($fell(owdIrq) |-> $past(apbWr) || $past(apbWr, 2))
		else $error("irq dropped without write");
endmodule

bind cws_clock_select cws_clock_select_checker i_chk (
	.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
	.pslverr(pslverr), .cpuClk(cpuClk), .cpuEdge(cpuEdge), .pllEnable(pllEnable),
	.pllFactor(pllFactor), .pllResync(pllResync), .owdIrq(owdIrq)
);

// ---- verification/cws_osc_model.sv ----
/*
 * crystal and free-running pll source model.
 * assumes mclk is much faster than both; edges stay 2+ cycles apart.
 */
module cws_osc_model (
	input wire logic mclk,
	input wire logic run,
	input wire logic pllOn,
	output logic xtal,
	output logic pll
);
	timeunit 1ns;
	timeprecision 1ns;
	int xCnt = 0;
	logic [1:0] pCnt = 2'h0;
	initial begin
		xtal = 1'h0;
		pll = 1'h0;
	end
	// high 3, low 5 cycles; a stopped crystal holds its level
	always @(posedge mclk) begin
		if (run) begin
			xCnt <= xCnt + 1;
			if (xCnt == (xtal ? 2 : 4)) begin
				xtal <= !xtal;
				xCnt <= 0;
			end
		end
	end
	// pll high 2, low 2 cycles; low while powered off
	always @(posedge mclk) begin
		pCnt <= pllOn ? pCnt + 2'h1 : 2'h0;
		pll <= pllOn & pCnt[1];
	end
endmodule

// ---- verification/tb_cws_clock_select.sv ----
/*
 * testbench for cws_clock_select: apb tasks, strap modes, failover.
 * assumes cws_osc_model as crystal and pll source.
 */
module tb_cws_clock_select;
	timeunit 1ns;
	timeprecision 1ns;
	import cws_pkg::*;
	logic mclk, rstn, swRstReq, xtal, pll, psel, penable, pwrite, run, err;
	logic pready, pslverr, cpuClk, cpuEdge, pllEnable, pllResync, owdIrq;
	logic [2:0] straps;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [4:0] pllFactor;
	logic [4:0] fac [8] = '{5'h10, 5'h01, 5'h0A, 5'h01, 5'h05, 5'h08, 5'h03, 5'h04};
	int failures = 0, checks_done = 0, g1, g2, n;

	initial begin
		mclk = 1'h0;
		forever #50 mclk = ~mclk;
	end

	cws_clock_select i_dut (.mclk(mclk), .rstn(rstn), .swRstReq(swRstReq), .crystalInputPin(xtal),
		.pllClkIn(pll), .clockModeStrapPins(straps), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cpuClk(cpuClk), .cpuEdge(cpuEdge), .pllEnable(pllEnable), .pllFactor(pllFactor),
		.pllResync(pllResync), .owdIrq(owdIrq));
	cws_osc_model i_osc (.mclk(mclk), .run(run), .pllOn(pllEnable), .xtal(xtal), .pll(pll));

	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge mclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'h1;
		do @(posedge mclk); while (pready !== 1'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	// cycles from now to the next cpu clock edge
	task gap(output int g);
		g = 0;
		do begin
			@(posedge mclk);
			g++;
		end while (cpuEdge !== 1'h1 && g < 50);
	endtask

	task boot(input logic [2:0] s);
		@(posedge mclk);
		straps <= s;
		swRstReq <= 1'h1;
		@(posedge mclk);
		swRstReq <= 1'h0;
		repeat (8) @(posedge mclk);
	endtask

	task end_sim;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge mclk);
		failures++;
		end_sim;
	end

	initial begin
		{rstn, swRstReq, psel, penable, pwrite} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		straps = STRAP_PRESCALE;
		run = 1'h1;
		repeat (20) @(posedge mclk);
		rstn <= 1'h1;
		repeat (6) @(posedge mclk);
		chk("pllEnable", pllEnable, 1'h1);
		chk("pllFactor", pllFactor, FACTOR_ONE);
		apb(1'h0, CLK_STATE_ADDR, 32'h0, rd, err);
		chk("clkState", rd[5:0], 6'h21);
		gap(n);
		gap(g1);
		gap(g2);
		chk("prescHigh", g1, 8);
		chk("prescLow", g2, 8);
		for (int c = 0; c < 8; c++) begin
			boot(3'(c));
			chk("factor", pllFactor, fac[c]);
			if (fac[c] != FACTOR_ONE) begin
				n = 0;
				while (pllResync !== 1'h1 && n < 300) begin
					@(posedge mclk);
					n++;
				end
				chk("resync", pllResync, 1'h1);
			end
		end
		boot(STRAP_DIRECT);
		gap(n);
		gap(g1);
		gap(g2);
		chk("directPeriod", g1 + g2, 8);
		chk("directDuty", g1 * g2, 15);
		apb(1'h0, 8'h10, 32'h0, rd, err);
		chk("slvErr", err, 1'h1);
		chk("errData", rd, 32'h0);
		apb(1'h1, IRQ_MASK_ADDR, 32'h1, rd, err);
		run <= 1'h0;
		n = 0;
		while (owdIrq !== 1'h1 && n < 300) begin
			@(posedge mclk);
			n++;
		end
		chk("owdIrq", owdIrq, 1'h1);
		chk("owdTime", n >= 55 && n <= 80, 1'h1);
		apb(1'h0, IRQ_STATUS_ADDR, 32'h0, rd, err);
		chk("irqStatus", rd[0], 1'h1);
		apb(1'h1, IRQ_MASK_ADDR, 32'h0, rd, err);
		repeat (2) @(posedge mclk);
		chk("irqMasked", owdIrq, 1'h0);
		apb(1'h1, IRQ_MASK_ADDR, 32'h1, rd, err);
		repeat (2) @(posedge mclk);
		chk("irqUnmasked", owdIrq, 1'h1);
		run <= 1'h1;
		repeat (20) @(posedge mclk);
		gap(n);
		gap(g1);
		chk("pllHalf", g1, 2);
		apb(1'h1, IRQ_STATUS_ADDR, 32'h1, rd, err);
		repeat (3) @(posedge mclk);
		chk("irqCleared", owdIrq, 1'h0);
		apb(1'h0, CLK_STATE_ADDR, 32'h0, rd, err);
		chk("failHeld", rd[4], 1'h1);
		boot(STRAP_DIRECT);
		apb(1'h0, CLK_STATE_ADDR, 32'h0, rd, err);
		chk("failCleared", rd[4], 1'h0);
		apb(1'h1, SYSCFG_ADDR, 32'h10, rd, err);
		apb(1'h0, SYSCFG_ADDR, 32'h0, rd, err);
		chk("sysCfg", rd, 32'h10);
		repeat (3) @(posedge mclk);
		chk("pllOff", pllEnable, 1'h0);
		gap(n);
		gap(g1);
		gap(g2);
		chk("offPeriod", g1 + g2, 8);
		run <= 1'h0;
		repeat (150) @(posedge mclk);
		chk("noIrq", owdIrq, 1'h0);
		end_sim;
	end
endmodule
